//--- rtl/fep_consts.svh
`ifndef FEP_CONSTS_SVH
`define FEP_CONSTS_SVH

// Timing, in the units printed, and the cycle counts derived at 20 MHz
`define FEP_CLK_KHZ       20000
`define FEP_LINK_UP_MS    50
`define FEP_WIN_MS        2
`define FEP_LINK_UP_CYC   (`FEP_LINK_UP_MS * `FEP_CLK_KHZ)
`define FEP_WIN_CYC       (`FEP_WIN_MS * `FEP_CLK_KHZ)
`define FEP_IDLE_RUN      16

// Register offsets (byte addresses)
`define FEP_REG_CTRL      8'h00
`define FEP_REG_STAT      8'h04

// Control fields, reset value and writable mask
`define FEP_CTRL_AN       0
`define FEP_CTRL_OVR      1
`define FEP_CTRL_BYP      2
`define FEP_CTRL_ADDR_LSB 4
`define FEP_CTRL_ADDR_MSB 8
`define FEP_CTRL_RST      9'h000
`define FEP_CTRL_MASK     9'h1F7

// Status fields
`define FEP_STAT_LINK     0
`define FEP_STAT_LINK2    1
`define FEP_STAT_LOCK     2
`define FEP_STAT_CRS      3
`define FEP_STAT_L10      4
`define FEP_STAT_FLP      5
`define FEP_STAT_POL      6

// Fixed scrambler seed bits, nonzero so the generator never sticks
`define FEP_SEED_HI       6'h2A

// Code groups and the preamble nibble
`define FEP_CG_I          5'h1F
`define FEP_CG_J          5'h18
`define FEP_CG_K          5'h11
`define FEP_CG_T          5'h0D
`define FEP_CG_R          5'h07
`define FEP_PREAMBLE      4'h5

`endif

//--- rtl/fep_pkg.sv
package fep_pkg;

   typedef logic [4:0] fep_cg_t;
   typedef logic [3:0] fep_nib_t;

   typedef enum logic [3:0] {
      tx_idle = 4'h1,
      tx_k    = 4'h2,
      tx_data = 4'h4,
      tx_r    = 4'h8
   } fep_tx_e;

   typedef enum logic [2:0] {
      rx_idle  = 3'h1,
      rx_pre   = 3'h2,
      rx_frame = 3'h4
   } fep_rx_e;

endpackage

//--- rtl/fep_link_if.sv
`timescale 1ns/100ps
interface fep_link_if;
   logic sym_stb;
   logic idle_cg;
   logic locked;
   logic link_up;
   logic link_drop;

   modport mon  (input sym_stb, idle_cg, output locked, link_up, link_drop);
   modport core (output sym_stb, idle_cg, input locked, link_up, link_drop);
endinterface

//--- rtl/fep_scr.sv
`timescale 1ns/100ps
module fep_scr (
   input  logic                clk,
   input  logic                rst,
   input  logic                step,
   input  logic                load,
   input  logic [10:0]         seed,
   input  logic                bypass,
   input  logic                resync,
   input  fep_pkg::fep_cg_t    din,
   output fep_pkg::fep_cg_t    dout
);
   logic [10:0]      state_reg;
   logic [10:0]      state_next;
   fep_pkg::fep_cg_t mixed;

   // Bit 4 goes first on the wire; taps at stages 11 and 9
   always_comb begin
      logic key;
      key        = 1'b0;
      state_next = state_reg;
      mixed      = din;
      for (int i = 4; i >= 0; i--) begin
         key        = state_next[10] ^ state_next[8];
         mixed[i]   = din[i] ^ key;
         // While hunting, an idle is assumed, so the key is the inverted bit
         state_next = {state_next[9:0], resync ? ~din[i] : key};
      end
   end

   assign dout = bypass ? din : mixed;

   always_ff @(posedge clk) begin
      if (rst || load) begin
         state_reg <= seed;
      end else if (step) begin
         state_reg <= state_next;
      end
   end
endmodule

//--- rtl/fep_link_mon.sv
`timescale 1ns/100ps
`include "fep_consts.svh"
module fep_link_mon #(
   parameter int UP_CYC   = `FEP_LINK_UP_CYC,
   parameter int WIN_CYC  = `FEP_WIN_CYC,
   parameter int IDLE_RUN = `FEP_IDLE_RUN
) (
   input  logic       clk,
   input  logic       rst,
   fep_link_if.mon    lk
);
   localparam int UW = $clog2(UP_CYC + 1);
   localparam int WW = $clog2(WIN_CYC + 1);
   localparam int RW = $clog2(IDLE_RUN + 1);

   generate
      if (UP_CYC < 2 || WIN_CYC < 2 || IDLE_RUN < 1) begin : g_bad
         $error("link monitor counts out of range");
      end
   endgenerate

   logic [RW-1:0] run_reg;
   logic [RW-1:0] run_next;
   logic [WW-1:0] win_reg;
   logic [WW-1:0] win_next;
   logic [UW-1:0] up_reg;
   logic [UW-1:0] up_next;
   logic          seen_reg;
   logic          lock_reg;
   logic          link_reg;
   logic          drop_reg;
   logic          run_hit;
   logic          win_end;
   logic          fail;
   logic          link_next;

   assign run_hit  = (run_reg == RW'(IDLE_RUN));
   assign run_next = !lk.sym_stb ? run_reg :
                     !lk.idle_cg ? '0 :
                     run_hit ? run_reg : run_reg + 1'b1;
   assign win_end  = (win_reg == WW'(WIN_CYC - 1));
   // A window with no full idle run drops lock and link
   assign fail     = lock_reg & win_end & ~seen_reg & ~run_hit;
   assign win_next = (!lock_reg || win_end) ? '0 : win_reg + 1'b1;
   assign up_next  = (!lock_reg || link_reg) ? '0 : up_reg + 1'b1;
   assign link_next = lock_reg & ~fail &
                      (link_reg | (up_reg == UW'(UP_CYC - 1)));

   always_ff @(posedge clk) begin
      if (rst) begin
         run_reg  <= '0;
         win_reg  <= '0;
         up_reg   <= '0;
         seen_reg <= 1'b0;
         lock_reg <= 1'b0;
         link_reg <= 1'b0;
         drop_reg <= 1'b0;
      end else begin
         run_reg  <= run_next;
         win_reg  <= win_next;
         up_reg   <= up_next;
         seen_reg <= (lock_reg && !win_end) && (seen_reg || run_hit);
         lock_reg <= ~fail & (lock_reg | run_hit);
         link_reg <= link_next;
         drop_reg <= link_reg & ~link_next;
      end
   end

   assign lk.locked    = lock_reg;
   assign lk.link_up   = link_reg;
   assign lk.link_drop = drop_reg;
endmodule

//--- rtl/fep_pcs.sv
`timescale 1ns/100ps
`include "fep_consts.svh"
// Operation
// - Idle code groups fill the line while transmit enable is low
// - First two frame nibbles are replaced by J then K
// - Further nibbles map to their fixed 5-bit data code groups
// - Frame end sends T then R, then idle fill resumes
// - Received J/K becomes two preamble nibbles; preamble always passed
// - Error and unassigned code groups never decode to a nibble
// - Non-data inside a frame raises receive error with nibble 0101
// - Link up after descrambler stays locked about 50 ms
// - Link drops without a 16-idle run in any 2 ms window
// - 10 Mbps indication from idle waveforms is withheld once the descrambler locks
// - Link loss shows in status; restarts negotiation when enabled
// - Data sent only with link up, unless the override bit is set with negotiation off
// - Negotiation enabled and link down sends bursts, not data
// - Carrier sense rises on J/K and falls on T/R
// - Idles without T/R drop carrier, receive error for one symbol
// - Receive data valid from first preamble to frame end, error groups included
// - Scramble everything, idles too; descrambler syncs on idles
// - Scrambler seed takes five bits from the management address
// - Bypass bit skips both scrambler and descrambler
// - Polarity status is meaningless at 100 Mbps
// - Device sources both MII clocks at the symbol rate
module fep_pcs #(
   parameter int UP_CYC  = `FEP_LINK_UP_CYC,
   parameter int WIN_CYC = `FEP_WIN_CYC
) (
   input  logic        clk,
   input  logic        rst,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [7:0]  paddr,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   input  logic        sym_clk,
   input  logic [4:0]  line_rx_cg,
   output logic [4:0]  line_tx_cg,
   output logic        mii_tx_clk,
   input  logic        mii_tx_en,
   input  logic [3:0]  mii_txd,
   output logic        mii_rx_clk,
   output logic        mii_rx_dv,
   output logic        mii_rx_er,
   output logic [3:0]  mii_rxd,
   output logic        mii_crs,
   input  logic        link10_ind,
   output logic        link10_up,
   output logic        flp_send,
   output logic        an_restart
);

   function automatic fep_pkg::fep_cg_t enc_nib(input fep_pkg::fep_nib_t n);
      fep_pkg::fep_cg_t c;
      case (n)
         4'h0:    c = 5'h1E;
         4'h1:    c = 5'h09;
         4'h2:    c = 5'h14;
         4'h3:    c = 5'h15;
         4'h4:    c = 5'h0A;
         4'h5:    c = 5'h0B;
         4'h6:    c = 5'h0E;
         4'h7:    c = 5'h0F;
         4'h8:    c = 5'h12;
         4'h9:    c = 5'h13;
         4'hA:    c = 5'h16;
         4'hB:    c = 5'h17;
         4'hC:    c = 5'h1A;
         4'hD:    c = 5'h1B;
         4'hE:    c = 5'h1C;
         default: c = 5'h1D;
      endcase
      return c;
   endfunction

   // Inverse search of the data table: anything else is non-data
   function automatic logic [4:0] dec_cg(input fep_pkg::fep_cg_t c);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (enc_nib(4'(i)) == c) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // Input synchronisers: symbol clock, MII transmit pins, line, 10M flag
   logic [11:0] in_s1_reg;
   logic [11:0] in_s2_reg;
   logic        sclk_d_reg;
   logic        mii_clk_reg;
   logic        sym_stb;
   logic        tx_en_s;
   logic [3:0]  txd_s;
   logic [4:0]  rx_cg_s;
   logic        link10_s;

   always_ff @(posedge clk) begin
      if (rst) begin
         in_s1_reg   <= 12'h000;
         in_s2_reg   <= 12'h000;
         sclk_d_reg  <= 1'b0;
         mii_clk_reg <= 1'b0;
      end else begin
         in_s1_reg   <= {sym_clk, mii_tx_en, mii_txd, line_rx_cg, link10_ind};
         in_s2_reg   <= in_s1_reg;
         sclk_d_reg  <= in_s2_reg[11];
         mii_clk_reg <= in_s2_reg[11];
      end
   end

   assign sym_stb  = in_s2_reg[11] & ~sclk_d_reg;
   assign tx_en_s  = in_s2_reg[10];
   assign txd_s    = in_s2_reg[9:6];
   assign rx_cg_s  = in_s2_reg[5:1];
   assign link10_s = in_s2_reg[0];

   // Both MII clocks follow the symbol clock, one cycle behind the strobe
   assign mii_tx_clk = mii_clk_reg;
   assign mii_rx_clk = mii_clk_reg;

   // APB slave, zero wait states; read data captured in the setup phase
   logic [8:0]  ctrl_reg;
   logic [31:0] prdata_reg;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        ctrl_wr;
   logic [31:0] stat_w;
   logic [31:0] rd_mux;
   logic        an_en;
   logic        ovr;
   logic        byp;
   logic [10:0] seed_w;

   assign hit_ctrl = (paddr == `FEP_REG_CTRL);
   assign hit_stat = (paddr == `FEP_REG_STAT);
   assign ctrl_wr  = psel & penable & pwrite & hit_ctrl;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~(hit_ctrl | hit_stat);
   assign prdata   = prdata_reg;
   assign rd_mux   = hit_ctrl ? {23'h000000, ctrl_reg} :
                     hit_stat ? stat_w : 32'h00000000;

   assign an_en  = ctrl_reg[`FEP_CTRL_AN];
   assign ovr    = ctrl_reg[`FEP_CTRL_OVR];
   assign byp    = ctrl_reg[`FEP_CTRL_BYP];
   assign seed_w = {`FEP_SEED_HI,
                    ctrl_reg[`FEP_CTRL_ADDR_MSB:`FEP_CTRL_ADDR_LSB]};

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg   <= `FEP_CTRL_RST;
         prdata_reg <= 32'h00000000;
      end else begin
         if (ctrl_wr) begin
            ctrl_reg <= pwdata[8:0] & `FEP_CTRL_MASK;
         end
         if (psel && !penable) begin
            prdata_reg <= rd_mux;
         end
      end
   end

   // Link monitor and the two scramblers
   fep_link_if       lk();
   fep_pkg::fep_cg_t tx_plain;
   fep_pkg::fep_cg_t tx_scr;
   fep_pkg::fep_cg_t rx_desc;
   fep_pkg::fep_cg_t rx_cur;

   assign lk.sym_stb = sym_stb;
   assign lk.idle_cg = (rx_desc == `FEP_CG_I);

   fep_link_mon #(
      .UP_CYC  (UP_CYC),
      .WIN_CYC (WIN_CYC)
   ) u_mon (
      .clk (clk),
      .rst (rst),
      .lk  (lk.mon)
   );

   // The seed is reloaded on every control write from the address held before that write,
   // so an address change takes effect at the next control write; the far end simply resynchronises
   fep_scr u_tx_scr (
      .clk    (clk),
      .rst    (rst),
      .step   (sym_stb),
      .load   (ctrl_wr),
      .seed   (seed_w),
      .bypass (byp),
      .resync (1'b0),
      .din    (tx_plain),
      .dout   (tx_scr)
   );

   fep_scr u_rx_scr (
      .clk    (clk),
      .rst    (rst),
      .step   (sym_stb),
      .load   (ctrl_wr),
      .seed   (seed_w),
      .bypass (byp),
      .resync (~lk.locked),
      .din    (rx_cg_s),
      .dout   (rx_desc)
   );

   // Transmit framing
   fep_pkg::fep_tx_e tx_st_reg;
   fep_pkg::fep_tx_e tx_st_next;
   logic             tx_ok;
   logic [4:0]       tx_cg_reg;

   assign tx_ok = (lk.link_up | ovr) & ~(an_en & ~lk.link_up);

   always_comb begin
      tx_st_next = tx_st_reg;
      tx_plain   = `FEP_CG_I;
      case (tx_st_reg)
         fep_pkg::tx_idle: begin
            if (tx_en_s && tx_ok) begin
               tx_plain   = `FEP_CG_J;
               tx_st_next = fep_pkg::tx_k;
            end
         end
         fep_pkg::tx_k: begin
            tx_plain   = `FEP_CG_K;
            tx_st_next = fep_pkg::tx_data;
         end
         fep_pkg::tx_data: begin
            if (tx_en_s) begin
               tx_plain = enc_nib(txd_s);
            end else begin
               tx_plain   = `FEP_CG_T;
               tx_st_next = fep_pkg::tx_r;
            end
         end
         fep_pkg::tx_r: begin
            tx_plain   = `FEP_CG_R;
            tx_st_next = fep_pkg::tx_idle;
         end
         default: begin
            tx_st_next = fep_pkg::tx_idle;
         end
      endcase
   end

   // The nibble taken is the one the MAC set up after the previous edge
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_st_reg <= fep_pkg::tx_idle;
         tx_cg_reg <= `FEP_CG_I;
      end else if (sym_stb) begin
         tx_st_reg <= tx_st_next;
         tx_cg_reg <= tx_scr;
      end
   end

   assign line_tx_cg = tx_cg_reg;

   // Receive: outputs run one symbol behind so J/K can be recognised
   fep_pkg::fep_rx_e rx_st_reg;
   fep_pkg::fep_rx_e rx_st_next;
   fep_pkg::fep_cg_t prev_reg;
   logic [4:0]       dec_w;
   logic             end_pair;
   logic             idle_cut;
   logic             crs_reg;
   logic             crs_next;
   logic             dv_reg;
   logic             dv_next;
   logic             er_reg;
   logic             er_next;
   logic [3:0]       rxd_reg;
   logic [3:0]       rxd_next;

   // An unlocked descrambler is read as idle, which closes any open frame
   assign rx_cur   = lk.locked ? rx_desc : `FEP_CG_I;
   assign dec_w    = dec_cg(prev_reg);
   assign end_pair = (prev_reg == `FEP_CG_T) && (rx_cur == `FEP_CG_R);
   assign idle_cut = (rx_cur == `FEP_CG_I);

   always_comb begin
      rx_st_next = rx_st_reg;
      crs_next   = crs_reg;
      dv_next    = dv_reg;
      er_next    = 1'b0;
      rxd_next   = rxd_reg;
      case (rx_st_reg)
         fep_pkg::rx_idle: begin
            if (prev_reg == `FEP_CG_J && rx_cur == `FEP_CG_K) begin
               rx_st_next = fep_pkg::rx_pre;
               crs_next   = 1'b1;
               dv_next    = 1'b1;
               rxd_next   = `FEP_PREAMBLE;
            end
         end
         fep_pkg::rx_pre: begin
            if (idle_cut) begin
               rx_st_next = fep_pkg::rx_idle;
               crs_next   = 1'b0;
               dv_next    = 1'b0;
               er_next    = 1'b1;
            end else begin
               rx_st_next = fep_pkg::rx_frame;
               rxd_next   = `FEP_PREAMBLE;
            end
         end
         fep_pkg::rx_frame: begin
            if (end_pair) begin
               rx_st_next = fep_pkg::rx_idle;
               crs_next   = 1'b0;
               dv_next    = 1'b0;
            end else if (idle_cut) begin
               rx_st_next = fep_pkg::rx_idle;
               crs_next   = 1'b0;
               dv_next    = 1'b0;
               er_next    = 1'b1;
            end else if (dec_w[4]) begin
               rxd_next = dec_w[3:0];
            end else begin
               er_next  = 1'b1;
               rxd_next = `FEP_PREAMBLE;
            end
         end
         default: begin
            rx_st_next = fep_pkg::rx_idle;
            crs_next   = 1'b0;
            dv_next    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_st_reg <= fep_pkg::rx_idle;
         prev_reg  <= `FEP_CG_I;
         crs_reg   <= 1'b0;
         dv_reg    <= 1'b0;
         er_reg    <= 1'b0;
         rxd_reg   <= 4'h0;
      end else if (sym_stb) begin
         rx_st_reg <= rx_st_next;
         prev_reg  <= rx_cur;
         crs_reg   <= crs_next;
         dv_reg    <= dv_next;
         er_reg    <= er_next;
         rxd_reg   <= rxd_next;
      end
   end

   assign mii_crs   = crs_reg;
   assign mii_rx_dv = dv_reg;
   assign mii_rx_er = er_reg;
   assign mii_rxd   = rxd_reg;

   // Side outputs: negotiation hooks and the 10 Mbps qualifier
   logic flp_reg;
   logic restart_reg;
   logic l10_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         flp_reg     <= 1'b0;
         restart_reg <= 1'b0;
         l10_reg     <= 1'b0;
      end else begin
         flp_reg     <= an_en & ~lk.link_up;
         restart_reg <= an_en & lk.link_drop;
         // Idle waveforms lock the descrambler within a few dozen
         // symbols, so a 10 Mbps indication seen while locked is withheld
         l10_reg     <= link10_s & ~lk.locked;
      end
   end

   assign flp_send   = flp_reg;
   assign an_restart = restart_reg;
   assign link10_up  = l10_reg;

   // Polarity reads zero: the 100 Mbps signalling has no polarity
   assign stat_w = {25'h0000000,
                    1'b0,
                    flp_reg,
                    l10_reg,
                    crs_reg,
                    lk.locked,
                    lk.link_up,
                    lk.link_up};

endmodule

//--- tb/fep_pcs_monitor.sv
`timescale 1ns/100ps
module fep_pcs_monitor (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       sym_clk,
   input wire logic [4:0] line_tx_cg,
   input wire logic       mii_tx_clk,
   input wire logic       mii_rx_clk,
   input wire logic       mii_rx_dv,
   input wire logic       mii_rx_er,
   input wire logic [3:0] mii_rxd,
   input wire logic       mii_crs,
   input wire logic       flp_send,
   input wire logic       an_restart
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // One symbol is eight clocks; six gives margin for the sync skew
   sequence s_hold(sig);
      $stable(sig)[*6];
   endsequence
   sequence s_er_pulse;
      mii_rx_er[*6] ##[1:3] !mii_rx_er;
   endsequence

   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("access not answered");
   apb_err_a: assert property (psel && penable |->
      (pslverr == !(paddr inside {8'h00, 8'h04})))
      else $error("error response wrong for address");
   crs_rise_a: assert property ($rose(mii_crs) |->
      mii_rx_dv && !mii_rx_er && mii_rxd == 4'h5)
      else $error("carrier rose without preamble nibble");
   dv_crs_a: assert property (mii_rx_dv |-> mii_crs)
      else $error("data valid without carrier");
   dv_fall_a: assert property ($fell(mii_crs) |-> !mii_rx_dv)
      else $error("data valid outlived carrier");
   er_nibble_a: assert property (mii_rx_er && mii_crs |->
      mii_rxd == 4'h5)
      else $error("error nibble not 0101");
   er_pulse_a: assert property ($fell(mii_crs) && mii_rx_er |->
      s_er_pulse)
      else $error("carrier loss error not one symbol");
   rxd_hold_a: assert property ($changed(mii_rxd) |=> s_hold(mii_rxd))
      else $error("receive nibble shorter than a symbol");
   txcg_hold_a: assert property ($changed(line_tx_cg) |=>
      s_hold(line_tx_cg))
      else $error("code group shorter than a symbol");
   mii_clk_a: assert property ($rose(sym_clk) |->
      ##[2:5] ($rose(mii_tx_clk) && mii_rx_clk))
      else $error("mii clocks not following symbol clock");
   restart_a: assert property (an_restart |=>
      !an_restart ##[0:2] flp_send)
      else $error("negotiation restart malformed");
endmodule

bind fep_pcs fep_pcs_monitor u_fep_pcs_monitor (
   .clk        (clk),
   .rst        (rst),
   .psel       (psel),
   .penable    (penable),
   .paddr      (paddr),
   .pready     (pready),
   .pslverr    (pslverr),
   .sym_clk    (sym_clk),
   .line_tx_cg (line_tx_cg),
   .mii_tx_clk (mii_tx_clk),
   .mii_rx_clk (mii_rx_clk),
   .mii_rx_dv  (mii_rx_dv),
   .mii_rx_er  (mii_rx_er),
   .mii_rxd    (mii_rxd),
   .mii_crs    (mii_crs),
   .flp_send   (flp_send),
   .an_restart (an_restart)
);

//--- tb/fep_mac_model.sv
`timescale 1ns/100ps
module fep_mac_model (
   input  wire logic  clk,
   input  wire logic  mii_tx_clk,
   output logic       mii_tx_en,
   output logic [3:0] mii_txd
);
   initial begin
      mii_tx_en = 1'b0;
      mii_txd = 4'h0;
   end

   // Gap is left to the caller, never timed from carrier sense
   task automatic send(input int len, input logic [3:0] nib [0:19]);
      for (int i = 0; i < len; i++) begin
         @(posedge mii_tx_clk);
         @(posedge clk);
         mii_tx_en <= 1'b1;
         mii_txd <= nib[i];
      end
      @(posedge mii_tx_clk);
      @(posedge clk);
      mii_tx_en <= 1'b0;
      mii_txd <= ~mii_txd;
   endtask
endmodule

//--- tb/test_fep_pcs.sv
`timescale 1ns/100ps
module test_fep_pcs;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sym_clk = 1'b0;
   logic [4:0]  line_rx_cg = 5'h1F;
   logic [4:0]  line_tx_cg;
   logic        mii_tx_clk;
   logic        mii_tx_en;
   logic [3:0]  mii_txd;
   logic        mii_rx_clk;
   logic        mii_rx_dv;
   logic        mii_rx_er;
   logic [3:0]  mii_rxd;
   logic        mii_crs;
   logic        link10_ind = 1'b0;
   logic        link10_up;
   logic        flp_send;
   logic        an_restart;
   int          n_fail = 0;
   int          checked = 0;
   int          n_restart = 0;
   int          k;
   logic        tcap = 1'b0;
   logic        rcap = 1'b0;
   logic [4:0]  tq[$];
   logic [6:0]  rq[$];
   logic [31:0] rd;
   logic        err;
   logic [3:0]  nib [0:19];
   logic [4:0]  enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
      5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

   fep_pcs #(.UP_CYC(200), .WIN_CYC(400)) u_fep_pcs (.*);
   fep_mac_model u_fep_mac_model (.clk(clk), .mii_tx_clk(mii_tx_clk),
      .mii_tx_en(mii_tx_en), .mii_txd(mii_txd));

   initial begin
      forever #25 clk = ~clk;
   end
   // Offset keeps the link clock edges away from the core clock edges
   initial begin
      #13;
      forever #200 sym_clk = ~sym_clk;
   end
   always @(negedge mii_tx_clk) if (tcap) tq.push_back(line_tx_cg);
   always @(negedge mii_rx_clk) if (rcap) begin
      rq.push_back({mii_crs, mii_rx_dv, mii_rx_er, mii_rxd});
   end
   always @(posedge clk) if (an_restart === 1'b1) n_restart++;

   task automatic chk(input logic [31:0] seen, exp, input string msg);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t %s: %h vs %h", $time, msg, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic sym(input logic [4:0] v);
      @(negedge sym_clk);
      @(posedge clk);
      line_rx_cg <= v;
   endtask

   task automatic tx_frame(input logic sent);
      int j;
      tq.delete();
      tcap = 1'b1;
      u_fep_mac_model.send(18, nib);
      repeat (5) @(posedge mii_tx_clk);
      tcap = 1'b0;
      j = 0;
      while (j < tq.size() && tq[j] !== 5'h18) j++;
      chk(tq[0], 5'h1F, "idle fill");
      if (!sent) chk(j == tq.size(), 1'b1, "frame refused");
      else begin
         chk(tq[j + 1], 5'h11, "start pair");
         for (int i = 0; i < 16; i++) chk(tq[j + 2 + i], enc[i], "data");
         chk({tq[j + 18], tq[j + 19], tq[j + 20]}, 15'h34FF, "end");
      end
      $display("tx frame test done");
   endtask

   task automatic rchk(input int i, input logic [1:0] f,
                       input logic [3:0] n);
      chk({rq[i][6], rq[i][4]}, f, "rx flags");
      chk(rq[i][5], f[1], "rx valid");
      if (f[1]) chk(rq[i][3:0], n, "rx nibble");
   endtask

   task automatic final_report;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      nib[0] = 4'h5;
      nib[1] = 4'h5;
      for (int i = 0; i < 16; i++) nib[i + 2] = i[3:0];
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0, "ctrl reset");
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0, "status reset");
      apb(1'b1, 8'h08, 32'hFFFF_FFFF);
      chk(err, 1'b1, "unmapped write");
      apb(1'b0, 8'h08, 32'h0);
      chk(err, 1'b1, "unmapped read error");
      chk(rd, 32'h0, "unmapped read data");
      apb(1'b1, 8'h00, 32'hFFFF_FFFF);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1F7, "ctrl mask");
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h20, "burst request");
      apb(1'b1, 8'h00, 32'h4);
      repeat (60) sym(5'h1F);
      link10_ind <= 1'b1;
      repeat (10) sym(5'h1F);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h7, "link up");
      chk(link10_up, 1'b0, "10M withheld");
      $display("register test done");
      tx_frame(1'b1);
      rq.delete();
      rcap = 1'b1;
      sym(5'h18);
      sym(5'h11);
      for (int i = 0; i < 16; i++) sym(enc[i]);
      sym(5'h04);
      sym(5'h0D);
      sym(5'h07);
      repeat (20) sym(5'h1F);
      sym(5'h18);
      sym(5'h11);
      sym(enc[3]);
      sym(enc[9]);
      // The last group before a cut is never presented
      sym(enc[6]);
      repeat (4) sym(5'h1F);
      rcap = 1'b0;
      k = 0;
      while (k < rq.size() && rq[k][6] !== 1'b1) k++;
      rchk(k, 2'b10, 4'h5);
      rchk(k + 1, 2'b10, 4'h5);
      for (int i = 0; i < 16; i++) rchk(k + 2 + i, 2'b10, i[3:0]);
      rchk(k + 18, 2'b11, 4'h5);
      rchk(k + 19, 2'b00, 4'h0);
      k = k + 20;
      while (k < rq.size() && rq[k][6] !== 1'b1) k++;
      rchk(k, 2'b10, 4'h5);
      rchk(k + 2, 2'b10, 4'h3);
      rchk(k + 3, 2'b10, 4'h9);
      rchk(k + 4, 2'b01, 4'h0);
      rchk(k + 5, 2'b00, 4'h0);
      $display("rx frame test done");
      apb(1'b1, 8'h00, 32'h5);
      repeat (120) sym(5'h1E);
      chk(n_restart, 1, "restart pulses");
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h30, "link lost");
      chk(link10_up, 1'b1, "10M flag once unlocked");
      tx_frame(1'b0);
      // Negotiation off, override on; no reception meanwhile
      apb(1'b1, 8'h00, 32'h6);
      tx_frame(1'b1);
      final_report();
   end

   initial begin
      #1_000_000;
      n_fail++;
      final_report();
   end
endmodule
